// ==== rtz_accumulator.sv ====
module rtz_accumulator (
  input  wire logic                           i_sys_clk,
  input  wire logic                           i_rst,
  input  wire logic                           i_load,
  input  wire logic [7:0]                     i_preload_value,
  input  wire logic                           i_enable,
  input  wire logic                           i_sd_bit,
  output logic      [rtz_stall_pkg::ACC_W-1:0] o_value
);

  logic [rtz_stall_pkg::ACC_W-1:0] value_d;

  // Preload is ~(16*PV), i.e. (-16*PV)-1 in two's complement
  function automatic logic [rtz_stall_pkg::ACC_W-1:0] preload_of(
    input logic [7:0] pv);
    return ~{3'h0, pv, 4'h0};
  endfunction : preload_of

  // Saturating up/down count of the sigma-delta bit stream
  always_comb begin
    value_d = o_value;
    if (i_load) begin
      value_d = preload_of(i_preload_value);
    end else if (i_enable) begin
      if (i_sd_bit && (o_value != 15'h3FFF)) begin
        value_d = o_value + 15'h0001;
      end else if (!i_sd_bit && (o_value != 15'h4000)) begin
        value_d = o_value - 15'h0001;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_value <= 15'h7FFF;
    end else begin
      o_value <= value_d;
    end
  end

  property p_preload;
    @(posedge i_sys_clk) disable iff (i_rst)
    i_load |=> o_value == ~{3'h0, $past(i_preload_value), 4'h0};
  endproperty
  a_preload: assert property (p_preload)
    else $error("accumulator preload value wrong");

  property p_idle_hold;
    @(posedge i_sys_clk) disable iff (i_rst)
    (!i_load && !i_enable) |=> $stable(o_value);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("accumulator moved outside integration");

endmodule : rtz_accumulator

// ==== rtz_host_model.sv ====
module rtz_host_model (
  input  wire logic        i_sys_clk,
  output logic             o_reg_wr,
  output logic [2:0]       o_reg_addr,
  output logic [12:0]      o_reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // Bus idles with the strobe low
  initial begin
    o_reg_wr    = 1'b0;
    o_reg_addr  = 3'h0;
    o_reg_wdata = 13'h0000;
  end

  // One-cycle write strobe; the host never reads the word back
  task automatic write_reg(input logic [2:0] addr,
                           input logic [12:0] data);
    @(posedge i_sys_clk);
    o_reg_wr    <= 1'b1;
    o_reg_addr  <= addr;
    o_reg_wdata <= data;
    @(posedge i_sys_clk);
    o_reg_wr    <= 1'b0;
    o_reg_wdata <= ~data; // Stale data does not linger
  endtask : write_reg
endmodule : rtz_host_model

// ==== rtz_stall_detect_config.sv ====
// Operation
// - Configuration word is written at serial register address 101.
// - Low four bits set full-step dwell; reset pattern 0101 gives 21.25 ms.
// - Step codes 0000/0001 give 4.86 ms, rising about 4.1 ms to 62.21.
// - Bit 4 selects blanking before integration: 512 us or 768 us.
// - Sigma-delta integration of undriven coil yields 15-bit result per step.
// - Result above threshold means moving; below means stall, ending the run.
// - Threshold is zero: sign 0 moving, sign 1 stopped.
// - Window select 10 or 11 puts accumulator bit 14 on status bit 14.
// - Integrator and accumulator restart at every full step.
// - Bits 12..5 give PV; each step starts at (-16*PV)-1.
// - After reset the initial accumulator value is -1.
// - Configuration is write-only; no copy is ever returned.
// - Return-to-zero uses full steps with one coil driven at a time.
// - Unconditional select ignores stalls; only disable stops motion.
module rtz_stall_detect_config #(
  parameter rtz_stall_pkg::step_tbl_type STEP_CYCLES =
    rtz_stall_pkg::STEP_CYC_DEF,
  parameter int unsigned BLANK_SHORT_CYCLES = rtz_stall_pkg::BLANK_SHORT_CYC,
  parameter int unsigned BLANK_LONG_CYCLES  = rtz_stall_pkg::BLANK_LONG_CYC
) (
  input  wire logic                              i_sys_clk,
  input  wire logic                              i_rst,
  input  wire logic                              i_reg_wr,
  input  wire logic [2:0]                        i_reg_addr,
  input  wire logic [rtz_stall_pkg::CFG_W-1:0]   i_reg_wdata,
  input  wire logic                              i_rtz_enable,
  input  wire logic                              i_unconditional_select,
  input  wire logic [1:0]                        i_window_select,
  input  wire logic                              i_sd_bit,
  output logic      [1:0]                        o_coil_phase,
  output logic                                   o_integrating,
  output logic                                   o_rtz_active,
  output logic                                   o_step_end,
  output logic                                   o_stall,
  output logic      [7:0]                        o_status_window
);

  // Elaboration checks on the timing parameters
  for (genvar g = 0; g < rtz_stall_pkg::NUM_STEPS; g++) begin : g_chk
    if (STEP_CYCLES[g] >= (1 << rtz_stall_pkg::CNT_W) ||
        STEP_CYCLES[g] <= BLANK_LONG_CYCLES) begin : g_bad
      $error("step cycle count out of range");
    end
  end
  if (BLANK_SHORT_CYCLES < 1 || BLANK_LONG_CYCLES < 1) begin : g_bad_blank
    $error("blank cycle count must be at least one");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_BLANK, ST_INTEG} state_type;

  localparam int CW = rtz_stall_pkg::CNT_W;

  state_type                            state_q, state_d;
  logic [CW-1:0]                        cnt_q, cnt_d;
  rtz_stall_pkg::rtz_cfg_type           pend_q, pend_d;
  rtz_stall_pkg::rtz_cfg_type           cfg_q, cfg_d;
  logic [1:0]                           phase_q, phase_d;
  logic                                 load_q, load_d;
  logic                                 integ_q, integ_d;
  logic                                 active_q, active_d;
  logic                                 end_q, end_d;
  logic                                 stall_q, stall_d;
  logic                                 done_q, done_d;
  logic [rtz_stall_pkg::ACC_W-1:0]      result_q, result_d;
  logic [7:0]                           status_q, status_d;
  logic [rtz_stall_pkg::ACC_W-1:0]      acc_value;
  logic                                 sd_ff1_q, sd_ff2_q, sd_ff3_q;
  logic                                 sd_q, sd_d;
  logic                                 cfg_wr;
  logic                                 blank_last;
  logic                                 step_last;
  logic                                 wrote_q, wrote_d;

  // Last cycle of the blanking interval for the select bit
  function automatic logic [CW-1:0] blank_last_cnt(input logic sel);
    return sel ? CW'(BLANK_LONG_CYCLES - 1) : CW'(BLANK_SHORT_CYCLES - 1);
  endfunction : blank_last_cnt

  // Last cycle of the full step for the step field
  function automatic logic [CW-1:0] step_last_cnt(input logic [3:0] f);
    return CW'(STEP_CYCLES[f] - 1);
  endfunction : step_last_cnt

  assign cfg_wr     = i_reg_wr && (i_reg_addr == rtz_stall_pkg::RTZ_CFG_ADDR);
  assign blank_last = cnt_q == blank_last_cnt(cfg_q.blank_time_select);
  assign step_last  = cnt_q == step_last_cnt(cfg_q.full_step_time_field);

  // Pin synchroniser; accepted bit moves when stages two and three agree
  always_comb begin
    sd_d = sd_q;
    if (sd_ff2_q == sd_ff3_q) begin
      sd_d = sd_ff3_q;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sd_ff1_q <= 1'b0;
      sd_ff2_q <= 1'b0;
      sd_ff3_q <= 1'b0;
      sd_q     <= 1'b0;
    end else begin
      sd_ff1_q <= i_sd_bit;
      sd_ff2_q <= sd_ff1_q;
      sd_ff3_q <= sd_ff2_q;
      sd_q     <= sd_d;
    end
  end

  // Step sequencer, configuration staging and stall decision
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q + CW'(1);
    pend_d   = pend_q;
    cfg_d    = cfg_q;
    phase_d  = phase_q;
    load_d   = 1'b0;
    integ_d  = 1'b0;
    active_d = active_q;
    end_d    = 1'b0;
    stall_d  = 1'b0;
    done_d   = done_q && i_rtz_enable;
    result_d = result_q;
    if (cfg_wr) begin
      pend_d = rtz_stall_pkg::rtz_cfg_type'(i_reg_wdata);
    end
    unique case (state_q)
      ST_IDLE: begin
        cnt_d = '0;
        cfg_d = pend_q;
        if (i_rtz_enable && !done_q) begin
          state_d  = ST_BLANK;
          phase_d  = phase_q - 2'h1;
          load_d   = 1'b1;
          active_d = 1'b1;
          result_d = '1;
        end
      end
      ST_BLANK: begin
        if (!i_rtz_enable) begin
          state_d  = ST_IDLE;
          active_d = 1'b0;
        end else if (blank_last) begin
          state_d = ST_INTEG;
          integ_d = 1'b1;
        end
      end
      ST_INTEG: begin
        integ_d = 1'b1;
        if (!i_rtz_enable) begin
          state_d  = ST_IDLE;
          active_d = 1'b0;
          integ_d  = 1'b0;
        end else if (step_last) begin
          end_d    = 1'b1;
          result_d = acc_value;
          integ_d  = 1'b0;
          if (acc_value[rtz_stall_pkg::ACC_W-1] &&
              !i_unconditional_select) begin
            state_d  = ST_IDLE;
            active_d = 1'b0;
            stall_d  = 1'b1;
            done_d   = 1'b1;
          end else begin
            state_d = ST_BLANK;
            cnt_d   = '0;
            cfg_d   = pend_q;
            phase_d = phase_q - 2'h1;
            load_d  = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q  <= ST_IDLE;
      cnt_q    <= '0;
      pend_q   <= rtz_stall_pkg::CFG_RESET;
      cfg_q    <= rtz_stall_pkg::CFG_RESET;
      phase_q  <= 2'h0;
      load_q   <= 1'b0;
      integ_q  <= 1'b0;
      active_q <= 1'b0;
      end_q    <= 1'b0;
      stall_q  <= 1'b0;
      done_q   <= 1'b0;
      result_q <= '0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      pend_q   <= pend_d;
      cfg_q    <= cfg_d;
      phase_q  <= phase_d;
      load_q   <= load_d;
      integ_q  <= integ_d;
      active_q <= active_d;
      end_q    <= end_d;
      stall_q  <= stall_d;
      done_q   <= done_d;
      result_q <= result_d;
    end
  end

  // Readback window onto status bits 15..8
  always_comb begin
    if (i_window_select == rtz_stall_pkg::WIN_LOW) begin
      status_d = result_q[7:0];
    end else if (i_window_select == rtz_stall_pkg::WIN_MID) begin
      status_d = result_q[11:4];
    end else begin
      status_d = {1'b0, result_q[14:8]};
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      status_q <= 8'h00;
    end else begin
      status_q <= status_d;
    end
  end

  // Accumulator, restarted by the step-start load pulse
  rtz_accumulator u_acc (
    .i_sys_clk       (i_sys_clk),
    .i_rst           (i_rst),
    .i_load          (load_q),
    .i_preload_value (cfg_q.preload_value),
    .i_enable        (integ_q),
    .i_sd_bit        (sd_q),
    .o_value         (acc_value)
  );

  assign o_coil_phase    = phase_q;
  assign o_integrating   = integ_q;
  assign o_rtz_active    = active_q;
  assign o_step_end      = end_q;
  assign o_stall         = stall_q;
  assign o_status_window = status_q;

  // Helper: set once a configuration write has been seen since reset
  assign wrote_d = wrote_q || cfg_wr;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wrote_q <= 1'b0;
    end else begin
      wrote_q <= wrote_d;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  property p_cfg_write;
    cfg_wr |=> pend_q == $past(i_reg_wdata);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("config write not captured");

  property p_default_cfg;
    !wrote_q |-> (cfg_q == rtz_stall_pkg::CFG_RESET);
  endproperty
  a_default_cfg: assert property (p_default_cfg)
    else $error("config not at default after reset");

  property p_step_len;
    (state_q == ST_INTEG) |->
      cnt_q <= step_last_cnt(cfg_q.full_step_time_field);
  endproperty
  a_step_len: assert property (p_step_len)
    else $error("full step overran its dwell time");

  property p_blank_end;
    (state_q == ST_BLANK && i_rtz_enable && blank_last) |=>
      state_q == ST_INTEG && o_integrating;
  endproperty
  a_blank_end: assert property (p_blank_end)
    else $error("integration did not start after blanking");

  property p_stall_stop;
    (state_q == ST_INTEG && i_rtz_enable && step_last &&
     acc_value[14] && !i_unconditional_select) |=>
      o_stall && !o_rtz_active ##1 !o_stall;
  endproperty
  a_stall_stop: assert property (p_stall_stop)
    else $error("stall did not end the run");

  property p_uncond;
    (state_q == ST_INTEG && i_rtz_enable && step_last &&
     i_unconditional_select) |=> o_rtz_active && load_q && !o_stall;
  endproperty
  a_uncond: assert property (p_uncond)
    else $error("unconditional run stopped on stall");

  property p_sign_window;
    i_window_select[1] |=> o_status_window[6] == $past(result_q[14]);
  endproperty
  a_sign_window: assert property (p_sign_window)
    else $error("status bit 14 is not the sign bit");

  property p_cfg_hold;
    (state_q != ST_IDLE && !load_d) |=> $stable(cfg_q);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("config changed inside a step");

  property p_phase_step;
    $changed(o_coil_phase) |-> $past(load_d) && load_q;
  endproperty
  a_phase_step: assert property (p_phase_step)
    else $error("coil phase moved off a step boundary");

endmodule : rtz_stall_detect_config

// ==== rtz_stall_pkg.sv ====
package rtz_stall_pkg;

  // Serial register address of the configuration word
  localparam logic [2:0] RTZ_CFG_ADDR = 3'h5;
  localparam int         CFG_W        = 13;
  localparam int         ACC_W        = 15;
  localparam int         CNT_W        = 21;
  localparam int         NUM_STEPS    = 16;

  // System clock period
  localparam int unsigned CLK_PERIOD_NS = 50;

  // Blanking times in microseconds
  localparam int unsigned BLANK_SHORT_US = 512;
  localparam int unsigned BLANK_LONG_US  = 768;

  typedef int unsigned step_tbl_type [NUM_STEPS];

  // Full-step dwell times in microseconds, indexed by the step field
  localparam step_tbl_type STEP_TIME_US = '{
    4860, 4860, 8960, 13060, 17150, 21250, 25340, 29440,
    33540, 37630, 41730, 45820, 49920, 54020, 58110, 62210};

  // Least times round up to whole cycles
  localparam int unsigned BLANK_SHORT_CYC =
    (BLANK_SHORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLANK_LONG_CYC =
    (BLANK_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Step time table converted to clock cycles
  function automatic step_tbl_type step_cycles_def();
    step_tbl_type t;
    for (int i = 0; i < NUM_STEPS; i++) begin
      t[i] = (STEP_TIME_US[i] * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    end
    return t;
  endfunction : step_cycles_def

  localparam step_tbl_type STEP_CYC_DEF = step_cycles_def();

  // Configuration word layout, msb first
  typedef struct packed {
    logic [7:0] preload_value;
    logic       blank_time_select;
    logic [3:0] full_step_time_field;
  } rtz_cfg_type;

  // Reset value: 21.25 ms steps, short blanking, preload 0 (-1)
  localparam rtz_cfg_type CFG_RESET = '{
    preload_value:        8'h00,
    blank_time_select:    1'b0,
    full_step_time_field: 4'h5};

  // Readback window select codes
  localparam logic [1:0] WIN_LOW  = 2'h0;
  localparam logic [1:0] WIN_MID  = 2'h1;

endpackage : rtz_stall_pkg

// ==== testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam rtz_stall_pkg::step_tbl_type STEPS = '{40, 40, 50, 60, 70,
    80, 90, 100, 110, 120, 130, 140, 150, 160, 170, 180};

  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        reg_wr;
  logic [2:0]  reg_addr;
  logic [12:0] reg_wdata;
  logic        rtz_enable = 1'b0;
  logic        uncond = 1'b0;
  logic [1:0]  win_sel = 2'h0;
  logic        sd_bit = 1'b1;
  logic [1:0]  coil_phase;
  logic        integrating;
  logic        rtz_active;
  logic        step_end;
  logic        stall;
  logic [7:0]  status_window;
  int          mismatches = 0;
  int          checks = 0;
  int          cyc = 0;

  // Clock and a free cycle count for intervals
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  rtz_host_model i_host (
    .i_sys_clk   (sys_clk),
    .o_reg_wr    (reg_wr),
    .o_reg_addr  (reg_addr),
    .o_reg_wdata (reg_wdata)
  );

  rtz_stall_detect_config #(
    .STEP_CYCLES        (STEPS),
    .BLANK_SHORT_CYCLES (4),
    .BLANK_LONG_CYCLES  (6)
  ) i_dut (
    .i_sys_clk              (sys_clk),
    .i_rst                  (rst),
    .i_reg_wr               (reg_wr),
    .i_reg_addr             (reg_addr),
    .i_reg_wdata            (reg_wdata),
    .i_rtz_enable           (rtz_enable),
    .i_unconditional_select (uncond),
    .i_window_select        (win_sel),
    .i_sd_bit               (sd_bit),
    .o_coil_phase           (coil_phase),
    .o_integrating          (integrating),
    .o_rtz_active           (rtz_active),
    .o_step_end             (step_end),
    .o_stall                (stall),
    .o_status_window        (status_window)
  );

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask : cmp

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  // Bounded wait for a step end or stall pulse
  task automatic wait_pulse(input bit on_stall, output int t);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while ((on_stall ? stall : step_end) !== 1'b1 && n < 500);
    t = cyc;
  endtask : wait_pulse

  // Configure while idle, then enable a run
  task automatic start_run(input logic [12:0] cfg, input logic sd);
    i_host.write_reg(3'h5, cfg);
    repeat (2) @(posedge sys_clk);
    sd_bit     <= sd;
    rtz_enable <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask : start_run

  task automatic stop_run;
    @(posedge sys_clk);
    rtz_enable <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : stop_run

  task automatic t_reset;
    cmp({coil_phase, integrating, rtz_active, step_end, stall},
        32'h0);
    cmp(status_window, 8'h00);
  endtask : t_reset

  // Default word: first result, dwell, phase, stall and no restart
  task automatic t_default;
    int t1;
    int t2;
    logic [1:0] p;
    sd_bit     <= 1'b1;
    rtz_enable <= 1'b1;
    repeat (3) @(posedge sys_clk);
    cmp(rtz_active, 1'b1);
    cmp(status_window, 8'hFF);
    wait_pulse(1'b0, t1);
    repeat (2) @(posedge sys_clk);
    p = coil_phase;
    wait_pulse(1'b0, t2);
    cmp(t2 - t1, STEPS[5]);
    repeat (2) @(posedge sys_clk);
    cmp(coil_phase, 2'(p - 2'h1));
    sd_bit  <= 1'b0;
    win_sel <= 2'h2;
    wait_pulse(1'b1, t1);
    cmp(stall, 1'b1);
    repeat (2) @(posedge sys_clk);
    cmp(status_window[7:6], 2'b01);
    repeat (20) @(posedge sys_clk);
    cmp(rtz_active, 1'b0);
    stop_run;
  endtask : t_default

  task automatic t_codes;
    int t1;
    int t2;
    for (int c = 0; c < 16; c++) begin
      start_run({8'h00, 1'b0, c[3:0]}, 1'b1);
      wait_pulse(1'b0, t1);
      wait_pulse(1'b0, t2);
      cmp(t2 - t1, STEPS[c]);
      repeat (2) @(posedge sys_clk);
      cmp(rtz_active, 1'b1);
      stop_run;
    end
  endtask : t_codes

  // Delay from step end to integration, short and long blanking
  task automatic t_blank;
    int t1;
    int k[2];
    for (int b = 0; b < 2; b++) begin
      start_run({8'h00, b[0], 4'h5}, 1'b1);
      wait_pulse(1'b0, t1);
      while (integrating !== 1'b0 && cyc < t1 + 50) @(posedge sys_clk);
      while (integrating !== 1'b1 && cyc < t1 + 50) @(posedge sys_clk);
      k[b] = cyc - t1;
      stop_run;
    end
    cmp(k[1] - k[0], 32'h2);
  endtask : t_blank

  // Deepest preload keeps a moving motor negative
  task automatic t_preload;
    int t;
    win_sel <= 2'h2;
    start_run({8'hFF, 1'b0, 4'h0}, 1'b1);
    wait_pulse(1'b1, t);
    cmp(stall, 1'b1);
    repeat (2) @(posedge sys_clk);
    cmp(status_window[7:6], 2'b01);
    // Preload -4081 plus 35 counted cycles leaves 15'h7032
    win_sel <= 2'h3;
    repeat (2) @(posedge sys_clk);
    cmp(status_window, 8'h70);
    win_sel <= 2'h1;
    repeat (2) @(posedge sys_clk);
    cmp(status_window, 8'h03);
    win_sel <= 2'h0;
    repeat (2) @(posedge sys_clk);
    cmp(status_window, 8'h32);
    stop_run;
  endtask : t_preload

  // Stalls ignored; a fresh step after negative ones still moves
  task automatic t_uncond;
    int t;
    uncond <= 1'b1;
    start_run({8'h00, 1'b0, 4'h0}, 1'b0);
    repeat (3) wait_pulse(1'b0, t);
    repeat (2) @(posedge sys_clk);
    cmp(rtz_active, 1'b1);
    uncond <= 1'b0;
    sd_bit <= 1'b1;
    wait_pulse(1'b0, t);
    repeat (2) @(posedge sys_clk);
    cmp(rtz_active, 1'b1);
    stop_run;
    cmp(rtz_active, 1'b0);
  endtask : t_uncond

  // Mid-run write lands at the boundary; address 4 is ignored
  task automatic t_midrun;
    int t1;
    int t2;
    int t3;
    start_run({8'h00, 1'b0, 4'h0}, 1'b1);
    wait_pulse(1'b0, t1);
    i_host.write_reg(3'h5, {8'h00, 1'b0, 4'h2});
    i_host.write_reg(3'h4, {8'h00, 1'b0, 4'hF});
    wait_pulse(1'b0, t2);
    wait_pulse(1'b0, t3);
    cmp(t2 - t1, STEPS[0]);
    cmp(t3 - t2, STEPS[2]);
    stop_run;
  endtask : t_midrun

  // Reset in mid-run stops it and brings back the default word
  task automatic t_rst_mid;
    int t1;
    int t2;
    start_run({8'hFF, 1'b1, 4'hF}, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset;
    wait_pulse(1'b0, t1);
    wait_pulse(1'b0, t2);
    cmp(t2 - t1, STEPS[5]);
    cmp(rtz_active, 1'b1);
    stop_run;
  endtask : t_rst_mid

  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    t_reset;
    t_default;
    t_codes;
    t_blank;
    t_preload;
    t_uncond;
    t_midrun;
    t_rst_mid;
    stop_test;
  end

  // Watchdog
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    $display("[ERR] %0t ns: watchdog expired", $time);
    stop_test;
  end
endmodule : testbench
